/* verilog/dioln_params.svh */
// Line counts, encodings, error code and timing counts for the digital line block.
`ifndef DIOLN_PARAMS_SVH
`define DIOLN_PARAMS_SVH
`define DIOLN_NUM_LINES 6
`define DIOLN_NUM_DEDICATED 3
`define DIOLN_FN_DEDICATED 2'h0
`define DIOLN_FN_HIGH 2'h1
`define DIOLN_FN_LOW 2'h2
`define DIOLN_FN_INPUT 2'h3
`define DIOLN_EDGE_FALL 2'h0
`define DIOLN_EDGE_RISE 2'h1
`define DIOLN_EDGE_BOTH 2'h2
`define DIOLN_CLK_HZ 10000000
`define DIOLN_PULSE_US 10
`define DIOLN_PULSE_CYC ((`DIOLN_CLK_HZ / 1000000) * `DIOLN_PULSE_US)
`define DIOLN_ERR_NOT_INPUT 10'h1fc
`endif

/* verilog/dioln_pkg.sv */
// Types shared by the digital line block.
package dioln_pkg;
    typedef logic [1:0] dioln_func_t;
    typedef enum logic [1:0] {
        DIOLN_P_IDLE = 2'h1,
        DIOLN_P_HIGH = 2'h2
    } dioln_pstate_t;
endpackage

/* verilog/dioln_pulse.sv */
// Retriggerable pulse stretcher used for the dedicated output roles.
`timescale 1ns/10ps
`include "dioln_params.svh"
module dioln_pulse
    import dioln_pkg::*;
#(
    parameter int CYCLES = `DIOLN_PULSE_CYC
) (
    input wire logic i_sys_clk, // System clock.
    input wire logic i_reset_n, // Asynchronous reset, active low.
    input wire logic i_fire, // One-cycle start request.
    output logic o_pulse // Registered pulse output.
);
    typedef struct packed {
        dioln_pstate_t st;
        logic [15:0] cnt;
        logic out;
    } dioln_pls_t;
    dioln_pls_t s_q, s_d;

    // A request during a running pulse restarts it, so closely spaced events merge into one longer pulse.
    always_comb begin
        s_d = s_q;
        case (s_q.st)
            DIOLN_P_IDLE: begin
                if (i_fire) begin
                    s_d.st = DIOLN_P_HIGH;
                    s_d.cnt = 16'(CYCLES - 1);
                    s_d.out = 1'b1;
                end
            end
            DIOLN_P_HIGH: begin
                if (i_fire) begin
                    s_d.cnt = 16'(CYCLES - 1);
                end else if (s_q.cnt == 16'h0000) begin
                    s_d.st = DIOLN_P_IDLE;
                    s_d.out = 1'b0;
                end else begin
                    s_d.cnt = s_q.cnt - 16'h0001;
                end
            end
            default: begin
                s_d.st = DIOLN_P_IDLE;
                s_d.out = 1'b0;
            end
        endcase
    end

    // State register.
    always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            s_q <= '{st: DIOLN_P_IDLE, cnt: 16'h0000, out: 1'b0};
        end else begin
            s_q <= s_d;
        end
    end

    assign o_pulse = s_q.out;
endmodule // dioln_pulse

/* verilog/dioln_top.sv */
// Six digital I/O lines with dedicated, manual output and manual input roles.
// Summary of operation
// - Six lines, each input or output.
// - Dedicated role only on lines one to three.
// - Line one dedicated: trigger, selectable edges.
// - Line two dedicated: 10 us completion pulse.
// - Line three dedicated: 10 us protection pulse.
// - Manual high drives the line high.
// - Manual low drives the line low.
// - Manual input releases the line.
// - Each line's function reads back.
// - Reading non-input line gives error 508.
`timescale 1ns/10ps
`include "dioln_params.svh"
module dioln_top
    import dioln_pkg::*;
#(
    parameter int NLINES = `DIOLN_NUM_LINES,
    parameter int PULSE_CYC = `DIOLN_PULSE_CYC
) (
    input wire logic i_sys_clk, // 10 MHz system clock.
    input wire logic i_reset_n, // Asynchronous reset, active low.
    input wire logic [2:0] i_cfg_line, // Line index 1..6 for a function write.
    input wire logic [1:0] i_cfg_func, // Function code to write.
    input wire logic i_cfg_wr, // One-cycle function write strobe.
    output logic o_cfg_reject, // Write refused, one cycle.
    input wire logic [1:0] i_trig_edge, // Trigger edge select for line one.
    input wire logic i_meas_done, // Settling elapsed, one-cycle pulse.
    input wire logic i_overvoltage_trip, // Overvoltage trip event, one cycle.
    input wire logic i_overcurrent_trip, // Overcurrent trip event, one cycle.
    input wire logic i_otp, // Overtemperature trip event, one cycle.
    input wire logic i_sense_rev, // Reversed sense leads event, one cycle.
    output logic o_trigger, // Trigger detected on line one, one cycle.
    input wire logic [2:0] i_rd_line, // Line index 1..6 for a read.
    input wire logic i_rd_req, // One-cycle read strobe.
    output logic [1:0] o_rd_func, // Function of the read line.
    output logic o_rd_data, // Input level of the read line.
    output logic o_rd_valid, // Read data valid, one cycle.
    output logic o_rd_err, // Read refused, one cycle.
    output logic [9:0] o_rd_err_code, // Error code with a non-input refusal; held for a bad index.
    input wire logic [5:0] i_line_in, // Pin input levels.
    output logic [5:0] o_line_out, // Pin output levels.
    output logic [5:0] o_line_oe // Pin output enables, high drives.
);
    typedef struct packed {
        dioln_func_t [5:0] func;
        logic [5:0] s1, s2, s3;
        logic [5:0] lvl;
        logic [5:0] out;
        logic [5:0] oe;
        logic trig;
        logic rej;
        logic [1:0] rfunc;
        logic rdata, rvalid, rerr;
        logic [9:0] rcode;
        logic [15:0] dlen;
    } dioln_st_t;
    dioln_st_t s_q, s_d;
    logic done_pulse, prot_pulse;
    logic prot_fire;
    logic [2:0] widx, ridx;

    assign prot_fire = i_overvoltage_trip | i_overcurrent_trip | i_otp | i_sense_rev;
    assign widx = i_cfg_line - 3'h1;
    assign ridx = i_rd_line - 3'h1;

    // Pulse stretchers for the completion and protection roles.
    dioln_pulse #(.CYCLES(PULSE_CYC)) u_done (
        .i_sys_clk(i_sys_clk),
        .i_reset_n(i_reset_n),
        .i_fire(i_meas_done),
        .o_pulse(done_pulse)
    );
    dioln_pulse #(.CYCLES(PULSE_CYC)) u_prot (
        .i_sys_clk(i_sys_clk),
        .i_reset_n(i_reset_n),
        .i_fire(prot_fire),
        .o_pulse(prot_pulse)
    );

    // Next-state logic: config writes, input sync, trigger detect, pin drive and reads.
    always_comb begin
        s_d = s_q;
        // Run length of the completion pulse, kept so its width can be checked for any pulse parameter.
        s_d.dlen = done_pulse ? s_q.dlen + 16'h0001 : 16'h0000;
        s_d.s1 = i_line_in;
        s_d.s2 = s_q.s1;
        s_d.s3 = s_q.s2;
        // A level only counts once two stages agree, filtering single-cycle glitches.
        for (int i = 0; i < 6; i++) begin
            if (s_q.s2[i] == s_q.s3[i]) begin
                s_d.lvl[i] = s_q.s3[i];
            end
        end
        s_d.rej = 1'b0;
        if (i_cfg_wr) begin
            if (i_cfg_line == 3'h0 || i_cfg_line > 3'(NLINES)) begin
                s_d.rej = 1'b1;
            end else if (i_cfg_func == `DIOLN_FN_DEDICATED && i_cfg_line > 3'(`DIOLN_NUM_DEDICATED)) begin
                s_d.rej = 1'b1;
            end else begin
                s_d.func[widx] = i_cfg_func;
            end
        end
        // Trigger edge detection on the filtered line-one level.
        s_d.trig = 1'b0;
        if (s_q.func[0] == `DIOLN_FN_DEDICATED && s_d.lvl[0] != s_q.lvl[0]) begin
            case (i_trig_edge)
                `DIOLN_EDGE_FALL: s_d.trig = ~s_d.lvl[0];
                `DIOLN_EDGE_RISE: s_d.trig = s_d.lvl[0];
                `DIOLN_EDGE_BOTH: s_d.trig = 1'b1;
                default: s_d.trig = 1'b0;
            endcase
        end
        // Pin drive from the current function.
        for (int i = 0; i < 6; i++) begin
            case (s_q.func[i])
                `DIOLN_FN_HIGH: begin
                    s_d.out[i] = 1'b1;
                    s_d.oe[i] = 1'b1;
                end
                `DIOLN_FN_LOW: begin
                    s_d.out[i] = 1'b0;
                    s_d.oe[i] = 1'b1;
                end
                `DIOLN_FN_DEDICATED: begin
                    s_d.out[i] = (i == 1) ? done_pulse : ((i == 2) ? prot_pulse : 1'b0);
                    s_d.oe[i] = (i == 1) || (i == 2);
                end
                default: begin
                    s_d.out[i] = 1'b0;
                    s_d.oe[i] = 1'b0;
                end
            endcase
        end
        // Read port: function for any line 1..6, data only for manual-input lines.
        s_d.rvalid = 1'b0;
        s_d.rerr = 1'b0;
        s_d.rdata = 1'b0;
        if (i_rd_req) begin
            if (i_rd_line == 3'h0 || i_rd_line > 3'(NLINES)) begin
                s_d.rerr = 1'b1;
            end else begin
                s_d.rvalid = 1'b1;
                s_d.rfunc = s_q.func[ridx];
                if (s_q.func[ridx] == `DIOLN_FN_INPUT) begin
                    s_d.rdata = s_q.lvl[ridx];
                end else begin
                    s_d.rerr = 1'b1;
                    s_d.rcode = `DIOLN_ERR_NOT_INPUT;
                end
            end
        end
    end

    // State register; dedicated roles on the low three lines after reset.
    always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            s_q <= '0;
            s_q.func <= {`DIOLN_FN_INPUT, `DIOLN_FN_INPUT, `DIOLN_FN_INPUT,
                         `DIOLN_FN_DEDICATED, `DIOLN_FN_DEDICATED, `DIOLN_FN_DEDICATED};
        end else begin
            s_q <= s_d;
        end
    end

    assign o_line_out = s_q.out;
    assign o_line_oe = s_q.oe;
    assign o_trigger = s_q.trig;
    assign o_cfg_reject = s_q.rej;
    assign o_rd_func = s_q.rfunc;
    assign o_rd_data = s_q.rdata;
    assign o_rd_valid = s_q.rvalid;
    assign o_rd_err = s_q.rerr;
    assign o_rd_err_code = s_q.rcode;

    // Assertions.
    property p_ded_reject;
        @(posedge i_sys_clk) disable iff (!i_reset_n)
        (i_cfg_wr && i_cfg_func == `DIOLN_FN_DEDICATED && i_cfg_line > 3'h3 && i_cfg_line < 3'h7) |=> o_cfg_reject;
    endproperty
    a_ded_reject: assert property (p_ded_reject) else $error("dedicated role accepted on high line");
    property p_high;
        @(posedge i_sys_clk) disable iff (!i_reset_n)
        (s_q.func[4] == `DIOLN_FN_HIGH) |=> (o_line_oe[4] && o_line_out[4]);
    endproperty
    a_high: assert property (p_high) else $error("manual high not driven");
    property p_low;
        @(posedge i_sys_clk) disable iff (!i_reset_n)
        (s_q.func[3] == `DIOLN_FN_LOW) |=> (o_line_oe[3] && !o_line_out[3]);
    endproperty
    a_low: assert property (p_low) else $error("manual low not driven");
    property p_input;
        @(posedge i_sys_clk) disable iff (!i_reset_n)
        (s_q.func[5] == `DIOLN_FN_INPUT) |=> !o_line_oe[5];
    endproperty
    a_input: assert property (p_input) else $error("input line driven");
    sequence s_done_start;
        (s_q.func[1] == `DIOLN_FN_DEDICATED) && !done_pulse && i_meas_done;
    endsequence
    property p_done;
        @(posedge i_sys_clk) disable iff (!i_reset_n)
        s_done_start |=> done_pulse;
    endproperty
    a_done: assert property (p_done) else $error("completion pulse missing");
    // A retriggered pulse runs longer, so only a short one is an error.
    sequence s_done_end;
        $fell(done_pulse);
    endsequence
    property p_done_len;
        @(posedge i_sys_clk) disable iff (!i_reset_n)
        s_done_end |-> (s_q.dlen >= 16'(PULSE_CYC));
    endproperty
    a_done_len: assert property (p_done_len) else $error("completion pulse too short");
    property p_prot;
        @(posedge i_sys_clk) disable iff (!i_reset_n)
        prot_fire |=> prot_pulse;
    endproperty
    a_prot: assert property (p_prot) else $error("protection pulse missing");
    property p_read_err;
        @(posedge i_sys_clk) disable iff (!i_reset_n)
        (i_rd_req && i_rd_line == 3'h1 && s_q.func[0] != `DIOLN_FN_INPUT)
            |=> (o_rd_err && o_rd_err_code == 10'h1fc);
    endproperty
    a_read_err: assert property (p_read_err) else $error("missing 508 error");
    property p_readback;
        @(posedge i_sys_clk) disable iff (!i_reset_n)
        (i_rd_req && i_rd_line == 3'h2) |=> (o_rd_valid && o_rd_func == $past(s_q.func[1]));
    endproperty
    a_readback: assert property (p_readback) else $error("function readback wrong");
    property p_trig_gate;
        @(posedge i_sys_clk) disable iff (!i_reset_n)
        o_trigger |-> $past(s_q.func[0]) == `DIOLN_FN_DEDICATED;
    endproperty
    a_trig_gate: assert property (p_trig_gate) else $error("trigger outside dedicated role");
endmodule // dioln_top

/* dv/dioln_ext.sv */
// External equipment model wired to the six digital lines.
`timescale 1ns/10ps
module dioln_ext (
    input wire logic i_sys_clk, // Clock that times pulses.
    input wire logic [5:0] i_out, // Levels the block drives.
    input wire logic [5:0] i_oe, // High where the block drives.
    input wire logic [5:0] i_lvl, // Levels the equipment drives.
    output logic [5:0] o_pin, // Resolved pin levels.
    output int o_w2, // Width of the last pulse on line two.
    output int o_w3, // Width of the last pulse on line three.
    output int o_np // Pulses seen on lines two and three.
);
    int c2;
    int c3;
    logic [1:0] hi;
    // The block wins where it drives; released lines follow the equipment.
    assign o_pin = (i_oe & i_out) | (~i_oe & i_lvl);
    assign hi = i_oe[2:1] & i_out[2:1];
    // Widths are measured on the wire so a wrong enable shows up too.
    always @(posedge i_sys_clk) begin
        c2 <= hi[0] ? c2 + 1 : 0;
        c3 <= hi[1] ? c3 + 1 : 0;
        if (hi[0])
            o_w2 <= c2 + 1;
        if (hi[1])
            o_w3 <= c3 + 1;
        o_np <= o_np + int'(hi[0] && c2 == 0) + int'(hi[1] && c3 == 0);
    end
endmodule // dioln_ext

/* dv/dioln_top_tb.sv */
// Self-checking bench for the six-line digital I/O block.
`timescale 1ns/10ps
`include "dioln_params.svh"
module dioln_top_tb;
    import dioln_pkg::*;
    localparam int PC = 5; // Short pulse keeps the run brief.
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [2:0] cfg_line = 3'h0;
    dioln_func_t cfg_func = 2'h0;
    logic cfg_wr = 1'b0;
    logic [1:0] edge_sel = 2'h0;
    logic meas = 1'b0;
    logic [3:0] ev = 4'h0;
    logic [2:0] rd_line = 3'h0;
    logic rd_req = 1'b0;
    logic [5:0] lvl = 6'h0;
    logic rej, trig, rvalid, rdat, rerr;
    logic [1:0] rfunc;
    logic [9:0] rcode;
    logic [5:0] pin, lout, loe;
    int w2, w3, np, k0;
    int errors = 0;
    int compares = 0;
    int ntrig = 0;
    int cyc = 0;
    dioln_func_t fn [1:6];
    logic [4:0] rq [$];
    logic [2:0] wq [$];
    logic [4:0] nt;

    dioln_top #(.PULSE_CYC(PC)) i_dioln_top (.i_sys_clk(clk), .i_reset_n(rst_n), .i_cfg_line(cfg_line),
        .i_cfg_func(cfg_func), .i_cfg_wr(cfg_wr), .o_cfg_reject(rej), .i_trig_edge(edge_sel),
        .i_meas_done(meas), .i_overvoltage_trip(ev[0]), .i_overcurrent_trip(ev[1]), .i_otp(ev[2]),
        .i_sense_rev(ev[3]),
        .o_trigger(trig), .i_rd_line(rd_line), .i_rd_req(rd_req), .o_rd_func(rfunc), .o_rd_data(rdat),
        .o_rd_valid(rvalid), .o_rd_err(rerr), .o_rd_err_code(rcode), .i_line_in(pin), .o_line_out(lout),
        .o_line_oe(loe));
    dioln_ext i_dioln_ext (.i_sys_clk(clk), .i_out(lout), .i_oe(loe), .i_lvl(lvl), .o_pin(pin),
        .o_w2(w2), .o_w3(w3), .o_np(np));

    // Free-running 10 MHz clock.
    always #50 clk = ~clk;

    task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            errors++;
            $display("unexpected %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic end_of_test;
        chk("queues_left", 16'(rq.size() + wq.size()), 16'h0);
        $display("compares %0d errors %0d", compares, errors);
        if (errors == 0 && compares > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // A write to a bad index or a dedicated role on lines four to six must be refused.
    task automatic wr(input logic [2:0] l, input dioln_func_t f);
        @(posedge clk);
        cfg_line <= l;
        cfg_func <= f;
        cfg_wr <= 1'b1;
        @(posedge clk);
        cfg_wr <= 1'b0;
        if (l == 3'h0 || l == 3'h7 || (l > 3'h3 && f == `DIOLN_FN_DEDICATED))
            wq.push_back(l);
        else
            fn[l] = f;
    endtask

    // Note layout is valid, error, function, data.
    task automatic rd(input logic [2:0] l);
        @(posedge clk);
        rd_line <= l;
        rd_req <= 1'b1;
        @(posedge clk);
        rd_req <= 1'b0;
        if (l == 3'h0 || l == 3'h7)
            rq.push_back(5'h08);
        else if (fn[l] == `DIOLN_FN_INPUT)
            rq.push_back({2'b10, fn[l], pin[l-1]});
        else
            rq.push_back({2'b11, fn[l], 1'b0});
    endtask

    // Watcher: sampled just after each edge so registered outputs have settled.
    always @(posedge clk) begin
        #1;
        cyc++;
        if (trig === 1'b1)
            ntrig++;
        if (rej === 1'b1) begin
            chk("cfg_reject", 16'(wq.size()), 16'h1);
            if (wq.size() != 0)
                void'(wq.pop_front());
        end
        if (rvalid === 1'b1 || rerr === 1'b1) begin
            nt = (rq.size() != 0) ? rq.pop_front() : 5'h1f;
            chk("rd_valid", 16'(rvalid), 16'(nt[4]));
            chk("rd_err", 16'(rerr), 16'(nt[3]));
            if (rerr === 1'b1)
                chk("rd_code", 16'(rcode), 16'(`DIOLN_ERR_NOT_INPUT));
            if (nt[4])
                chk("rd_func", 16'(rfunc), 16'(nt[2:1]));
            if (nt[4])
                chk("rd_data", 16'(rdat), 16'(nt[0]));
        end
        if (cyc == 20000) begin
            errors++;
            end_of_test;
        end
    end

    // Main sequence; the timeout guards against a hung handshake.
    initial begin
        fn = '{`DIOLN_FN_DEDICATED, `DIOLN_FN_DEDICATED, `DIOLN_FN_DEDICATED,
            `DIOLN_FN_INPUT, `DIOLN_FN_INPUT, `DIOLN_FN_INPUT};
        k0 = $urandom(44);
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        for (int l = 1; l <= 6; l++)
            rd(3'(l));
        rd(3'h0);
        rd(3'h7);
        for (int f = 1; f <= 3; f++) begin
            for (int l = 1; l <= 6; l++) begin
                lvl <= 6'($urandom);
                wr(3'(l), 2'(f));
                // A released line needs the enable edge, three sync stages and the filter stage before its level reads back.
                repeat (6) @(posedge clk);
                chk("line_oe", 16'(loe[l-1]), 16'(f != 3));
                if (f != 3)
                    chk("line_out", 16'(lout[l-1]), 16'(f == 1));
                rd(3'(l));
            end
        end
        wr(3'h0, `DIOLN_FN_HIGH);
        wr(3'h7, `DIOLN_FN_HIGH);
        for (int l = 1; l <= 6; l++)
            wr(3'(l), `DIOLN_FN_DEDICATED);
        for (int l = 1; l <= 6; l++)
            rd(3'(l));
        lvl <= 6'h0;
        for (int e = 0; e < 4; e++) begin
            edge_sel <= 2'(e);
            repeat (8) @(posedge clk);
            k0 = ntrig;
            lvl[0] <= 1'b1;
            repeat (8) @(posedge clk);
            lvl[0] <= 1'b0;
            repeat (8) @(posedge clk);
            chk("trig_count", 16'(ntrig - k0), 16'(e == 2 ? 2 : (e == 3 ? 0 : 1)));
        end
        for (int k = 0; k < 5; k++) begin
            k0 = np;
            if (k == 0)
                meas <= 1'b1;
            else
                ev <= 4'(1 << (k - 1));
            @(posedge clk);
            meas <= 1'b0;
            ev <= 4'h0;
            repeat (PC + 8) @(posedge clk);
            chk("pulse_count", 16'(np - k0), 16'h1);
            chk("pulse_width", 16'(k == 0 ? w2 : w3), 16'(PC));
        end
        repeat (4) @(posedge clk);
        end_of_test;
    end
endmodule // dioln_top_tb
